/* File: dv/virtual_uart_host_regs_bench.sv */
// self-checking bench for the host register block with its serial partner
// assumes axi4-lite on aclk and the partner model on the character streams
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, (g), (e)); end end
module virtual_uart_host_regs_bench
    import vuh_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, push = 0, hold = 0;
    logic awready, wready, bvalid, arready, rvalid, rxv, txv, txr, term, sreq;
    logic rrdy, trdy, lsi, rdi, hei;
    logic [1:0] bresp, rresp, r;
    logic [7:0] txc, last_tx, d;
    logic [15:0] baud;
    vuh_rx_char_t push_char = '0, rxc;
    vuh_frame_t frame;
    int tx_count, failures = 0, checks_done = 0;
    typedef struct packed {logic [7:0] a; logic [7:0] v; logic [10:0] e;} vuh_row_t;
    vuh_row_t rows [10] = '{'{8'h0C, 8'h00, {4'd5, 2'd0, 5'b00100}},
        '{8'h0C, 8'h05, {4'd6, 2'd2, 5'b00100}}, '{8'h0C, 8'h04, {4'd5, 2'd1, 5'b00100}},
        '{8'h0C, 8'h1A, {4'd7, 2'd0, 5'b11000}}, '{8'h0C, 8'h2B, {4'd8, 2'd0, 5'b10110}},
        '{8'h0C, 8'h7F, {4'd8, 2'd2, 5'b11011}}, '{8'h10, 8'h01, 11'h2},
        '{8'h10, 8'h02, 11'h1}, '{8'h10, 8'h03, 11'h0}, '{8'h10, 8'h00, 11'h3}};
    logic [7:0] trig [4] = '{8'h02, 8'h82, 8'h4A, 8'hC2};
    int tn [4] = '{1, 4, 8, 8};

    always #5 aclk = ~aclk;

    vuh_regs i_vuh_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_char_valid(rxv), .rx_char(rxc), .tx_char_ready(txr), .tx_char_valid(txv),
        .tx_char(txc), .frame_cfg(frame), .baud_divisor(baud), .mcu_terminal_ready_input(term),
        .mcu_send_request_input(sreq), .receive_ready_pin(rrdy), .transmit_ready_pin(trdy),
        .line_status_irq(lsi), .rx_data_irq(rdi), .holding_empty_irq(hei));
    vuh_serial_model i_vuh_serial_model (.aclk(aclk), .push(push), .push_char(push_char),
        .hold(hold), .tx_char_valid(txv), .tx_char(txc), .rx_char_valid(rxv), .rx_char(rxc),
        .tx_char_ready(txr), .last_tx(last_tx), .tx_count(tx_count));

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awready) ad = 1'b1;
            if (wready) wd = 1'b1;
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        @(posedge aclk);
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic push_n(input vuh_rx_char_t c, input int n);
        @(posedge aclk);
        push <= 1'b1;
        push_char <= c;
        repeat (n) @(posedge aclk);
        push <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h14);
        `CHK(d, VUH_LSR_RESET)
        rd(8'h08);
        `CHK(d[7], 1'b1)
        rd(8'h40);
        `CHK(r, VUH_RESP_SLVERR)
        wr(8'h40, 8'hFF);
        `CHK(r, VUH_RESP_SLVERR)
        for (int i = 0; i < 10; i++) begin
            wr(rows[i].a, rows[i].v);
            `CHK(rows[i].a == 8'h0C ? frame : {9'h0, sreq, term}, rows[i].e)
        end
        wr(8'h0C, 8'h83);
        wr(8'h00, 8'h0C);
        wr(8'h04, 8'h01);
        wr(8'h0C, 8'h03);
        wr(8'h04, 8'h07);
        `CHK(baud, 16'h010C)
        `CHK(hei, 1'b1)
        @(posedge aclk) hold <= 1'b1;
        wr(8'h00, 8'hA5);
        wr(8'h00, 8'h5A);
        rd(8'h14);
        `CHK({hei, trdy, d[6:5]}, 4'b0100)
        @(posedge aclk) hold <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK({last_tx, 8'(tx_count)}, 16'h5A02)
        rd(8'h14);
        `CHK(d[6:5], 2'b11)
        @(posedge aclk) hold <= 1'b1;
        wr(8'h00, 8'h77);
        wr(8'h08, 8'h04);
        `CHK(txv, 1'b0)
        @(posedge aclk) hold <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK(tx_count, 2)
        push_n({3'b000, 8'h31}, 17);
        `CHK(lsi, 1'b1)
        rd(8'h14);
        `CHK(d[1:0], 2'b11)
        rd(8'h14);
        `CHK(d[1:0], 2'b01)
        rd(8'h00);
        `CHK(d, 8'h31)
        wr(8'h08, 8'h02);
        rd(8'h14);
        `CHK(d[0], 1'b0)
        for (int i = 0; i < 3; i++) begin
            push_n({3'(1 << i), 8'h55}, 1);
            `CHK(lsi, 1'b1)
            rd(8'h14);
            `CHK(d[7], 1'b1)
            rd(8'h00);
            rd(8'h14);
            `CHK(d, 8'hE0 | 8'(4 << i))
            rd(8'h14);
            `CHK({lsi, d}, 9'h060)
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h08, trig[i]);
            if (tn[i] > 1) push_n('0, tn[i] - 1);
            `CHK({rdi, rrdy}, {1'b0, trig[i][3] | (tn[i] == 1)})
            push_n('0, 1);
            `CHK({rdi, rrdy}, 2'b10)
        end
        wr(8'h10, 8'h03);
        @(posedge aclk) aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK({term, sreq, baud, lsi, rdi}, 20'hC_0000)
        rd(8'h14);
        `CHK(d, VUH_LSR_RESET)
        wrap_up();
    end
endmodule

/* File: dv/vuh_regs_assertions.sv */
// concurrent checks on the host register block ports
// assumes a master that offers write address and data together
`timescale 1ns/1ps
module vuh_regs_checker
    import vuh_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_char_valid,
    input wire vuh_frame_t frame_cfg,
    input wire logic mcu_terminal_ready_input,
    input wire logic mcu_send_request_input,
    input wire logic holding_empty_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    property reg_set(a, ok);
        wt && s_axi_awaddr == a |=> ##1 ok;
    endproperty
    term_ready_a: assert property (
        reg_set(32'h10, mcu_terminal_ready_input == !$past(s_axi_wdata[0], 2))) else $error("dtr");
    send_req_a: assert property (
        reg_set(32'h10, mcu_send_request_input == !$past(s_axi_wdata[1], 2))) else $error("rts");
    word_len_a: assert property (
        reg_set(32'h0C, frame_cfg.data_bits == 4'd5 + $past(s_axi_wdata[1:0], 2)))
        else $error("word length");
    brk_ctl_a: assert property (
        reg_set(32'h0C, frame_cfg.break_on == $past(s_axi_wdata[6], 2))) else $error("break");
    stick_val_a: assert property (
        reg_set(32'h0C, frame_cfg.parity_stick ==
        ($past(s_axi_wdata[3], 2) && $past(s_axi_wdata[5], 2)) &&
        frame_cfg.parity_stick_val == !$past(s_axi_wdata[4], 2))) else $error("stick");
    half_stop_a: assert property (
        frame_cfg.stop == VUH_STOP_ONE_HALF |-> frame_cfg.data_bits == 4'd5) else $error("stop");
    tx_clear_a: assert property (
        wt && s_axi_awaddr == 32'h08 && s_axi_wdata[2] |=> ##1 !tx_char_valid)
        else $error("tx clear");
    holding_empty_flag_irq_a: assert property (
        holding_empty_irq |-> !tx_char_valid) else $error("holding_empty_flag irq");
    fifo_on_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h08 |=> s_axi_rvalid
        && s_axi_rdata[7]) else $error("fifo enable");
    bresp_time_a: assert property (
        wt |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("bvalid");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata");
    cover property (wt && s_axi_awaddr == 32'h0C);
    cover property (holding_empty_irq);
    cover property (s_axi_rvalid && s_axi_rresp == VUH_RESP_SLVERR);
endmodule
bind vuh_regs vuh_regs_checker i_vuh_regs_checker (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tx_char_valid, .frame_cfg, .mcu_terminal_ready_input,
    .mcu_send_request_input, .holding_empty_irq);

/* File: dv/vuh_serial_model.sv */
// serial-side partner: feeds received characters, takes transmit characters
// assumes the bench drives push, push_char and hold just after a rising edge
`timescale 1ns/1ps
module vuh_serial_model
    import vuh_pkg::*;
(
    input wire logic aclk,
    input wire logic push,
    input wire vuh_rx_char_t push_char,
    input wire logic hold,
    input wire logic tx_char_valid,
    input wire logic [7:0] tx_char,
    output logic rx_char_valid,
    output vuh_rx_char_t rx_char,
    output logic tx_char_ready,
    output logic [7:0] last_tx,
    output int tx_count
);
    initial begin
        rx_char_valid = 1'b0;
        rx_char = '0;
        last_tx = '0;
        tx_count = 0;
    end
    // stalls the transmit side while hold is high
    assign tx_char_ready = !hold;
    // idle character lines show the inverse of the last value
    always @(posedge aclk) begin
        rx_char_valid <= push;
        rx_char <= push ? push_char : ~rx_char;
        if (tx_char_valid && !hold) begin
            last_tx <= tx_char;
            tx_count <= tx_count + 1;
        end
    end
endmodule

/* File: rtl/vuh_pkg.sv */
// package for the virtual uart host register block
// assumes a 32-bit axi4-lite master and a serial-side character source
package vuh_pkg;
    // register indices as printed, byte address is four times the index
    localparam logic [3:0] VUH_IDX_DATA = 4'h0;
    localparam logic [3:0] VUH_IDX_IER = 4'h1;
    localparam logic [3:0] VUH_IDX_FCR = 4'h2;
    localparam logic [3:0] VUH_IDX_LCR = 4'h3;
    localparam logic [3:0] VUH_IDX_MCR = 4'h4;
    localparam logic [3:0] VUH_IDX_LSR = 4'h5;
    localparam logic [3:0] VUH_IDX_LAST = 4'h7;
    localparam logic [7:0] VUH_FCR_RESET = 8'h00;
    localparam logic [7:0] VUH_LCR_RESET = 8'h00;
    localparam logic [7:0] VUH_MCR_RESET = 8'h00;
    localparam logic [7:0] VUH_LSR_RESET = 8'h60;
    localparam logic [7:0] VUH_IIR_FIFO_ON = 8'h80;
    localparam int VUH_FCR_EN = 0;
    localparam int VUH_FCR_RXCLR = 1;
    localparam int VUH_FCR_TXCLR = 2;
    localparam int VUH_FCR_MODE = 3;
    localparam int VUH_FCR_TRIG_LO = 6;
    localparam int VUH_FCR_TRIG_HI = 7;
    localparam int VUH_LCR_STB = 2;
    localparam int VUH_LCR_PEN = 3;
    localparam int VUH_LCR_EPS = 4;
    localparam int VUH_LCR_STICK = 5;
    localparam int VUH_LCR_BRK = 6;
    localparam int VUH_LCR_DIVISOR_ACCESS_BIT = 7;
    localparam int VUH_MCR_DTR = 0;
    localparam int VUH_MCR_RTS = 1;
    localparam int VUH_FIFO_DEPTH = 16;
    localparam int VUH_PTR_W = 4;
    localparam logic [4:0] VUH_TRIG_1 = 5'h01;
    localparam logic [4:0] VUH_TRIG_4 = 5'h04;
    localparam logic [4:0] VUH_TRIG_8 = 5'h08;
    localparam int VUH_BAUD_REF_HZ = 115200;
    localparam logic [1:0] VUH_RESP_OKAY = 2'b00;
    localparam logic [1:0] VUH_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        VUH_STOP_ONE = 2'b00,
        VUH_STOP_ONE_HALF = 2'b01,
        VUH_STOP_TWO = 2'b10
    } vuh_stop_t;

    // character framing handed to the serial engine
    typedef struct packed {
        logic [3:0] data_bits;
        vuh_stop_t stop;
        logic parity_on;
        logic parity_even;
        logic parity_stick_val;
        logic parity_stick;
        logic break_on;
    } vuh_frame_t;

    // received character with its error tags
    typedef struct packed {
        logic brk;
        logic frm;
        logic par;
        logic [7:0] data;
    } vuh_rx_char_t;
endpackage

/* File: rtl/vuh_regs.sv */
// host register block of the virtual uart: fifo, line, modem control, line status
// assumes axi4-lite on aclk; serial engine and firmware side on the same clock
`timescale 1ns/1ps
module vuh_regs
    import vuh_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_char_valid,
    input wire vuh_rx_char_t rx_char,
    input wire logic tx_char_ready,
    output logic tx_char_valid,
    output logic [7:0] tx_char,
    output vuh_frame_t frame_cfg,
    output logic [15:0] baud_divisor,
    output logic mcu_terminal_ready_input,
    output logic mcu_send_request_input,
    output logic receive_ready_pin,
    output logic transmit_ready_pin,
    output logic line_status_irq,
    output logic rx_data_irq,
    output logic holding_empty_irq
);
    logic [7:0] fifo_control_reg;
    logic [7:0] line_control_reg;
    logic [7:0] modem_line_control_reg;
    logic [7:0] int_enable_reg;
    logic [7:0] divisor_low_reg;
    logic [7:0] divisor_high_byte;
    logic overrun_reg;
    logic lsr_err_hold_reg;
    logic err_summary_reg;
    logic [2:0] head_err_reg;
    logic aw_full_reg;
    logic w_full_reg;
    logic [3:0] aw_idx_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    vuh_rx_char_t rx_mem [VUH_FIFO_DEPTH];
    logic [7:0] tx_mem [VUH_FIFO_DEPTH];
    logic [VUH_PTR_W-1:0] rx_rd_reg;
    logic [VUH_PTR_W-1:0] rx_wr_reg;
    logic [VUH_PTR_W:0] rx_cnt_reg;
    logic [VUH_PTR_W-1:0] tx_rd_reg;
    logic [VUH_PTR_W-1:0] tx_wr_reg;
    logic [VUH_PTR_W:0] tx_cnt_reg;
    logic [VUH_FIFO_DEPTH-1:0] rx_err_vec_reg;

    // write channel
    wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    wire wr_ok = s_axi_awaddr[1:0] == 2'b00;
    wire divisor_access_bit = line_control_reg[VUH_LCR_DIVISOR_ACCESS_BIT];
    wire wr_lane = wstrb_reg[0];
    wire wr_fcr = do_write && wr_lane && aw_idx_reg == VUH_IDX_FCR;
    wire wr_lcr = do_write && wr_lane && aw_idx_reg == VUH_IDX_LCR;
    wire wr_mcr = do_write && wr_lane && aw_idx_reg == VUH_IDX_MCR;
    wire wr_thr = do_write && wr_lane && aw_idx_reg == VUH_IDX_DATA && !divisor_access_bit;
    wire wr_dll = do_write && wr_lane && aw_idx_reg == VUH_IDX_DATA && divisor_access_bit;
    wire wr_ier = do_write && wr_lane && aw_idx_reg == VUH_IDX_IER && !divisor_access_bit;
    wire wr_dlm = do_write && wr_lane && aw_idx_reg == VUH_IDX_IER && divisor_access_bit;
    wire rx_clear = wr_fcr && wdata_reg[VUH_FCR_RXCLR];
    wire tx_clear = wr_fcr && wdata_reg[VUH_FCR_TXCLR];

    // read channel
    wire [3:0] ar_idx = s_axi_araddr[5:2];
    wire ar_take = s_axi_arvalid && !rvalid_reg;
    wire ar_map = s_axi_araddr[1:0] == 2'b00 && s_axi_araddr[31:6] == 26'h000_0000 &&
        ar_idx <= VUH_IDX_LAST;
    wire rd_lsr = ar_take && ar_map && ar_idx == VUH_IDX_LSR;
    wire rd_rbr = ar_take && ar_map && ar_idx == VUH_IDX_DATA && !divisor_access_bit;

    // receive fifo
    wire rx_empty = rx_cnt_reg == '0;
    wire rx_full = rx_cnt_reg == (VUH_PTR_W+1)'(VUH_FIFO_DEPTH);
    wire rx_pop = rd_rbr && !rx_empty;
    wire rx_push = rx_char_valid && (!rx_full || rx_pop);
    wire rx_ovr = rx_char_valid && rx_full && !rx_pop;
    vuh_rx_char_t rx_head;
    assign rx_head = rx_mem[rx_rd_reg];
    wire [7:0] rx_head_data = rx_empty ? 8'h00 : rx_head.data;
    wire [2:0] head_err = rx_empty ? 3'b000 : {rx_head.brk, rx_head.frm, rx_head.par};
    wire any_err_in_fifo = |rx_err_vec_reg;

    // transmit fifo
    wire tx_empty = tx_cnt_reg == '0;
    wire tx_full = tx_cnt_reg == (VUH_PTR_W+1)'(VUH_FIFO_DEPTH);
    wire tx_push = wr_thr && !tx_full;
    wire tx_pop = tx_char_valid && tx_char_ready;

    // rx threshold
    logic [4:0] trig_level;
    always_comb begin
        case (fifo_control_reg[VUH_FCR_TRIG_HI:VUH_FCR_TRIG_LO])
            2'b00: trig_level = VUH_TRIG_1;
            2'b10: trig_level = VUH_TRIG_4;
            2'b01: trig_level = VUH_TRIG_8;
            default: trig_level = VUH_TRIG_8;
        endcase
    end

    // line status composition
    wire [7:0] lsr_val = {
        any_err_in_fifo | err_summary_reg,
        tx_empty,
        tx_empty,
        head_err_reg[2] | head_err[2],
        head_err_reg[1] | head_err[1],
        head_err_reg[0] | head_err[0],
        overrun_reg,
        !rx_empty
    };
    wire [7:0] iir_val = VUH_IIR_FIFO_ON | 8'h01;
    wire [7:0] fcr_rd = fifo_control_reg | 8'h01;

    logic [7:0] rd_byte;
    always_comb begin
        case (ar_idx)
            VUH_IDX_DATA: rd_byte = divisor_access_bit ? divisor_low_reg : rx_head_data;
            VUH_IDX_IER: rd_byte = divisor_access_bit ? divisor_high_byte : int_enable_reg;
            VUH_IDX_FCR: rd_byte = iir_val;
            VUH_IDX_LCR: rd_byte = line_control_reg;
            VUH_IDX_MCR: rd_byte = modem_line_control_reg;
            VUH_IDX_LSR: rd_byte = lsr_val;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_idx_reg <= 4'h0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= VUH_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                aw_idx_reg <= (wr_ok && s_axi_awaddr[31:6] == 26'h000_0000) ?
                    s_axi_awaddr[5:2] : 4'hf;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= aw_idx_reg > VUH_IDX_LAST ? VUH_RESP_SLVERR : VUH_RESP_OKAY;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= VUH_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h00_0000, ar_map ? rd_byte : 8'h00};
            rresp_reg <= ar_map ? VUH_RESP_OKAY : VUH_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fifo_control_reg <= VUH_FCR_RESET;
            line_control_reg <= VUH_LCR_RESET;
            modem_line_control_reg <= VUH_MCR_RESET;
            int_enable_reg <= 8'h00;
            divisor_low_reg <= 8'h00;
            divisor_high_byte <= 8'h00;
        end else begin
            if (wr_fcr) fifo_control_reg <= {wdata_reg[7:6], 2'b00, wdata_reg[3], 3'b000};
            if (wr_lcr) line_control_reg <= wdata_reg[7:0];
            if (wr_mcr) modem_line_control_reg <= {6'h00, wdata_reg[1:0]};
            if (wr_ier) int_enable_reg <= {4'h0, wdata_reg[3:0]};
            if (wr_dll) divisor_low_reg <= wdata_reg[7:0];
            if (wr_dlm) divisor_high_byte <= wdata_reg[7:0];
        end
    end

    // receive and transmit fifo storage, receive entries with their error tags
    always_ff @(posedge aclk) begin
        if (rx_push) rx_mem[rx_wr_reg] <= rx_char;
        if (tx_push) tx_mem[tx_wr_reg] <= wdata_reg[7:0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || rx_clear) begin
            rx_rd_reg <= '0;
            rx_wr_reg <= '0;
            rx_cnt_reg <= '0;
            rx_err_vec_reg <= '0;
        end else begin
            if (rx_push) rx_wr_reg <= rx_wr_reg + 1'b1;
            if (rx_pop) rx_rd_reg <= rx_rd_reg + 1'b1;
            rx_cnt_reg <= rx_cnt_reg + (VUH_PTR_W+1)'(rx_push) - (VUH_PTR_W+1)'(rx_pop);
            if (rx_pop) rx_err_vec_reg[rx_rd_reg] <= 1'b0;
            if (rx_push) rx_err_vec_reg[rx_wr_reg] <= |{rx_char.brk, rx_char.frm, rx_char.par};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || tx_clear) begin
            tx_rd_reg <= '0;
            tx_wr_reg <= '0;
            tx_cnt_reg <= '0;
        end else begin
            if (tx_push) tx_wr_reg <= tx_wr_reg + 1'b1;
            if (tx_pop) tx_rd_reg <= tx_rd_reg + 1'b1;
            tx_cnt_reg <= tx_cnt_reg + (VUH_PTR_W+1)'(tx_push) - (VUH_PTR_W+1)'(tx_pop);
        end
    end

    // sticky status, a new event in the read cycle wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overrun_reg <= 1'b0;
            head_err_reg <= 3'b000;
            lsr_err_hold_reg <= 1'b0;
            err_summary_reg <= 1'b0;
        end else begin
            overrun_reg <= rx_ovr | (overrun_reg & !rd_lsr);
            head_err_reg <= head_err | (head_err_reg & {3{!rd_lsr}});
            lsr_err_hold_reg <= rx_ovr | (|head_err) | (lsr_err_hold_reg & !rd_lsr);
            err_summary_reg <= any_err_in_fifo | (err_summary_reg & !rd_lsr);
        end
    end

    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready = !w_full_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    assign tx_char_valid = !tx_empty;
    assign tx_char = tx_mem[tx_rd_reg];

    assign frame_cfg.data_bits = 4'd5 + {2'b00, line_control_reg[1:0]};
    assign frame_cfg.stop = !line_control_reg[VUH_LCR_STB] ? VUH_STOP_ONE :
        (line_control_reg[1:0] == 2'b00 ? VUH_STOP_ONE_HALF : VUH_STOP_TWO);
    assign frame_cfg.parity_on = line_control_reg[VUH_LCR_PEN];
    assign frame_cfg.parity_even = line_control_reg[VUH_LCR_EPS];
    assign frame_cfg.parity_stick = line_control_reg[VUH_LCR_PEN] &&
        line_control_reg[VUH_LCR_STICK];
    assign frame_cfg.parity_stick_val = !line_control_reg[VUH_LCR_EPS];
    assign frame_cfg.break_on = line_control_reg[VUH_LCR_BRK];
    assign baud_divisor = {divisor_high_byte, divisor_low_reg};

    assign mcu_terminal_ready_input = !modem_line_control_reg[VUH_MCR_DTR];
    assign mcu_send_request_input = !modem_line_control_reg[VUH_MCR_RTS];

    // fifos always on, so mode bit alone picks the pin behaviour
    wire pin_mode1 = fcr_rd[VUH_FCR_MODE] && fcr_rd[VUH_FCR_EN];
    wire rx_at_trig = rx_cnt_reg >= trig_level;
    assign receive_ready_pin = pin_mode1 ? !rx_at_trig : rx_empty;
    assign transmit_ready_pin = pin_mode1 ? tx_full : !tx_empty;

    assign line_status_irq = lsr_err_hold_reg && int_enable_reg[2];
    assign rx_data_irq = rx_at_trig && int_enable_reg[0];
    assign holding_empty_irq = tx_empty && int_enable_reg[1];
endmodule
